// >>> fifo_pkg.sv
package fifo_pkg;

  // ----------------------------------------------------------------
  // geometry defaults
  // ----------------------------------------------------------------
  localparam int DEPTH_DEF  = 256;
  localparam int WIDTH_DEF  = 9;
  localparam int DEPTH_MIN  = 256;
  localparam int DEPTH_MAX  = 8192;
  localparam int BYTE_W     = 8;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] OFFSET_RST_LOW  = 8'h07;
  localparam logic [7:0] OFFSET_RST_HIGH = 8'h00;
  localparam logic       EMPTY_N_RST     = 1'b0;
  localparam logic       ALMOST_EMPTY_RST = 1'b0;
  localparam logic       FULL_N_RST      = 1'b1;
  localparam logic       ALMOST_FULL_RST = 1'b1;
  localparam logic       DRIVE_OFF_RST   = 1'b1;
  localparam logic       LOAD_MODE_RST   = 1'b0;

  // ----------------------------------------------------------------
  // offset register sequence, gray coded along the wrap
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_EMPTY_LOW  = 2'b00,
    SEL_EMPTY_HIGH = 2'b01,
    SEL_FULL_LOW   = 2'b11,
    SEL_FULL_HIGH  = 2'b10
  } thr_sel_t;

endpackage

// >>> fifo_ctl_if.sv
interface fifo_ctl_if #(
  parameter int AW = 8
);
  logic          clear;
  logic          wr_stb;
  logic          rd_stb;
  logic          ld_wr;
  logic          ld_rd;
  logic [7:0]    wr_byte;
  logic [7:0]    rd_byte;
  logic [AW-1:0] empty_thr;
  logic [AW-1:0] full_thr;
  logic [AW:0]   next_count;
  logic          empty_n;
  logic          full_n;
  logic          almost_empty_n;
  logic          almost_full_n;

  modport core  (output clear, wr_stb, rd_stb, ld_wr, ld_rd, wr_byte, next_count,
                 input  rd_byte, empty_n, full_n, almost_empty_n, almost_full_n);
  modport regs  (input  clear, ld_wr, ld_rd, wr_byte,
                 output rd_byte, empty_thr, full_thr);
  modport flags (input  clear, wr_stb, rd_stb, next_count, empty_thr, full_thr,
                 output empty_n, full_n, almost_empty_n, almost_full_n);
endinterface

// >>> thresh_regs.sv
module thresh_regs
  import fifo_pkg::*;
#(
  parameter int AW = 8
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control bundle
  fifo_ctl_if.regs  bus
);

  logic [7:0] empty_threshold_low;
  logic [7:0] empty_threshold_high;
  logic [7:0] full_threshold_low;
  logic [7:0] full_threshold_high;
  thr_sel_t   wr_sel;
  thr_sel_t   rd_sel;
  logic [15:0] empty_word;
  logic [15:0] full_word;

  function automatic thr_sel_t step(input thr_sel_t s);
    case (s)
      SEL_EMPTY_LOW:  step = SEL_EMPTY_HIGH;
      SEL_EMPTY_HIGH: step = SEL_FULL_LOW;
      SEL_FULL_LOW:   step = SEL_FULL_HIGH;
      default:        step = SEL_EMPTY_LOW;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // offset write sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || bus.clear) begin
      empty_threshold_low  <= OFFSET_RST_LOW;
      empty_threshold_high <= OFFSET_RST_HIGH;
      full_threshold_low   <= OFFSET_RST_LOW;
      full_threshold_high  <= OFFSET_RST_HIGH;
      wr_sel               <= SEL_EMPTY_LOW;
    end else if (bus.ld_wr) begin
      case (wr_sel)
        SEL_EMPTY_LOW:  empty_threshold_low  <= bus.wr_byte;
        SEL_EMPTY_HIGH: empty_threshold_high <= bus.wr_byte;
        SEL_FULL_LOW:   full_threshold_low   <= bus.wr_byte;
        default:        full_threshold_high  <= bus.wr_byte;
      endcase
      // position advances on each load write, wrapping from full high to empty low
      wr_sel <= step(wr_sel);
    end
  end

  // ----------------------------------------------------------------
  // offset read sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || bus.clear) begin
      rd_sel <= SEL_EMPTY_LOW;
    end else if (bus.ld_rd) begin
      rd_sel <= step(rd_sel);
    end
  end

  always_comb begin
    case (rd_sel)
      SEL_EMPTY_LOW:  bus.rd_byte = empty_threshold_low;
      SEL_EMPTY_HIGH: bus.rd_byte = empty_threshold_high;
      SEL_FULL_LOW:   bus.rd_byte = full_threshold_low;
      default:        bus.rd_byte = full_threshold_high;
    endcase
  end

  // upper offset bits beyond the array depth are stored but ignored
  assign empty_word    = {empty_threshold_high, empty_threshold_low};
  assign full_word     = {full_threshold_high, full_threshold_low};
  assign bus.empty_thr = empty_word[AW-1:0];
  assign bus.full_thr  = full_word[AW-1:0];

  seq_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus.ld_wr && !bus.clear && wr_sel == SEL_FULL_HIGH |=> wr_sel == SEL_EMPTY_LOW)
    else $error("offset write sequence did not wrap");

  seq_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !bus.ld_wr && !bus.clear |=> $stable(wr_sel))
    else $error("offset write position moved without a load write");

endmodule

// >>> flag_gen.sv
module flag_gen
  import fifo_pkg::*;
#(
  parameter int AW    = 8,
  parameter int DEPTH = DEPTH_DEF
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control bundle
  fifo_ctl_if.flags bus
);

  localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

  logic [AW:0] free_cnt;

  assign free_cnt = DEPTH_CNT - bus.next_count;

  // ----------------------------------------------------------------
  // read side flags: change only on read edges
  // ----------------------------------------------------------------
  // a write just before or in the same cycle as a read edge shows up at that read edge
  always_ff @(posedge clk_i) begin
    if (rst_i || bus.clear) begin
      bus.empty_n        <= EMPTY_N_RST;
      bus.almost_empty_n <= ALMOST_EMPTY_RST;
    end else if (bus.rd_stb) begin
      bus.empty_n        <= (bus.next_count != '0);
      bus.almost_empty_n <= (bus.next_count > {1'b0, bus.empty_thr});
    end
  end

  // ----------------------------------------------------------------
  // write side flags: change only on write edges
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || bus.clear) begin
      bus.full_n        <= FULL_N_RST;
      bus.almost_full_n <= ALMOST_FULL_RST;
    end else if (bus.wr_stb) begin
      bus.full_n        <= (bus.next_count != DEPTH_CNT);
      bus.almost_full_n <= (free_cnt > {1'b0, bus.full_thr});
    end
  end

  empty_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !bus.rd_stb && !bus.clear |=> $stable(bus.empty_n) && $stable(bus.almost_empty_n))
    else $error("read side flag moved without a read edge");

  full_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !bus.wr_stb && !bus.clear |=> $stable(bus.full_n) && $stable(bus.almost_full_n))
    else $error("write side flag moved without a write edge");

  almost_empty_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus.rd_stb && !bus.clear && bus.next_count <= {1'b0, bus.empty_thr}
    |=> !bus.almost_empty_n)
    else $error("almost empty not low at or below threshold");

  almost_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus.wr_stb && !bus.clear && free_cnt > {1'b0, bus.full_thr} |=> bus.almost_full_n)
    else $error("almost full low with room above threshold");

endmodule

// >>> sync_fifo_chan.sv
module sync_fifo_chan
  import fifo_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEF,
  parameter int WIDTH = WIDTH_DEF
) (
  // system
  input  wire logic             REF_CLK_I,
  input  wire logic             RST_I,
  input  wire logic             CLEAR_N_I,
  // write port
  input  wire logic             WR_CLK_I,
  input  wire logic             WR_EN_PRIMARY_N_I,
  input  wire logic             WR_EN_SECOND_OR_LOAD_I,
  input  wire logic [WIDTH-1:0] WR_DATA_I,
  // read port
  input  wire logic             RD_CLK_I,
  input  wire logic             RD_EN_PRIMARY_N_I,
  input  wire logic             RD_EN_SECOND_N_I,
  input  wire logic             OUT_DRIVE_EN_N_I,
  output logic      [WIDTH-1:0] RD_DATA_O,
  output logic                  RD_DATA_OE_N_O,
  // flags
  output logic                  EMPTY_FLAG_N_O,
  output logic                  FULL_FLAG_N_O,
  output logic                  ALMOST_EMPTY_N_O,
  output logic                  ALMOST_FULL_N_O
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic [WIDTH-1:0] rd_word;
  logic             drive_off;

  // ----------------------------------------------------------------
  // strobes and mode
  // ----------------------------------------------------------------
  logic wr_clk_q;
  logic rd_clk_q;
  logic load_mode;
  logic ld_active;
  logic wr_req;
  logic rd_req;
  logic fifo_wr;
  logic fifo_rd;

  fifo_ctl_if #(.AW(AW)) bus ();

  thresh_regs #(.AW(AW)) u_regs (
    .clk_i (REF_CLK_I),
    .rst_i (RST_I),
    .bus   (bus)
  );

  flag_gen #(.AW(AW), .DEPTH(DEPTH)) u_flags (
    .clk_i (REF_CLK_I),
    .rst_i (RST_I),
    .bus   (bus)
  );

  // ----------------------------------------------------------------
  // clock pin edge detection
  // ----------------------------------------------------------------
  // pins are synchronous to the reference clock, so edges run free
  // through clear as well; nothing here waits for clocks to stop
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      wr_clk_q <= 1'b0;
      rd_clk_q <= 1'b0;
    end else begin
      wr_clk_q <= WR_CLK_I;
      rd_clk_q <= RD_CLK_I;
    end
  end

  assign bus.clear  = !CLEAR_N_I;
  assign bus.wr_stb = WR_CLK_I && !wr_clk_q;
  assign bus.rd_stb = RD_CLK_I && !rd_clk_q;

  // ----------------------------------------------------------------
  // mode strap
  // ----------------------------------------------------------------
  // follows the pin for as long as clear is low; frozen after release
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      load_mode <= LOAD_MODE_RST;
    end else if (!CLEAR_N_I) begin
      load_mode <= !WR_EN_SECOND_OR_LOAD_I;
    end
  end

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  // requests during clear are dropped rather than trusted
  assign ld_active = load_mode && !WR_EN_SECOND_OR_LOAD_I;
  assign wr_req    = bus.wr_stb && !WR_EN_PRIMARY_N_I && CLEAR_N_I;
  assign rd_req    = bus.rd_stb && !RD_EN_PRIMARY_N_I && !RD_EN_SECOND_N_I && CLEAR_N_I;

  // in both modes the pin must be high for a queue write: second
  // enable in one mode, load released in the other
  assign fifo_wr   = wr_req && WR_EN_SECOND_OR_LOAD_I && bus.full_n;
  assign bus.ld_wr = wr_req && ld_active;
  assign bus.ld_rd = rd_req && ld_active;
  assign fifo_rd   = rd_req && !ld_active && bus.empty_n;

  assign bus.wr_byte = WR_DATA_I[BYTE_W-1:0];

  // ----------------------------------------------------------------
  // pointers
  // ----------------------------------------------------------------
  assign next_wr_ptr    = wr_ptr + (AW+1)'(fifo_wr);
  assign next_rd_ptr    = rd_ptr + (AW+1)'(fifo_rd);
  assign bus.next_count = next_wr_ptr - next_rd_ptr;

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || !CLEAR_N_I) begin
      wr_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || !CLEAR_N_I) begin
      rd_ptr <= '0;
    end else begin
      rd_ptr <= next_rd_ptr;
    end
  end

  // ----------------------------------------------------------------
  // array
  // ----------------------------------------------------------------
  // no reset on the array: contents are only visible once written
  always_ff @(posedge REF_CLK_I) begin
    if (fifo_wr) begin
      mem[wr_ptr[AW-1:0]] <= WR_DATA_I;
    end
  end

  // ----------------------------------------------------------------
  // output register
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || !CLEAR_N_I) begin
      rd_word <= '0;
    end else if (bus.ld_rd) begin
      rd_word <= WIDTH'(bus.rd_byte);
    end else if (fifo_rd) begin
      rd_word <= mem[rd_ptr[AW-1:0]];
    end
  end

  // pin release costs one reference cycle of latency
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      drive_off <= DRIVE_OFF_RST;
    end else begin
      drive_off <= OUT_DRIVE_EN_N_I;
    end
  end

  assign RD_DATA_O        = rd_word;
  assign RD_DATA_OE_N_O   = drive_off;
  assign EMPTY_FLAG_N_O   = bus.empty_n;
  assign FULL_FLAG_N_O    = bus.full_n;
  assign ALMOST_EMPTY_N_O = bus.almost_empty_n;
  assign ALMOST_FULL_N_O  = bus.almost_full_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  full_block_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CLEAR_N_I && !FULL_FLAG_N_O && bus.wr_stb |=> wr_ptr == $past(wr_ptr))
    else $error("write accepted while full");

  empty_hold_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CLEAR_N_I && !EMPTY_FLAG_N_O && !bus.ld_rd |=> $stable(RD_DATA_O))
    else $error("output word changed while empty");

  read_step_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CLEAR_N_I && EMPTY_FLAG_N_O && rd_req && !ld_active
    |=> rd_ptr == $past(rd_ptr) + 1'b1)
    else $error("valid read did not advance the read pointer");

  clear_state_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !CLEAR_N_I |=> !EMPTY_FLAG_N_O && !ALMOST_EMPTY_N_O && FULL_FLAG_N_O
                   && ALMOST_FULL_N_O && RD_DATA_O == '0)
    else $error("clear did not reach the empty condition");

  strap_take_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !CLEAR_N_I |=> load_mode == !$past(WR_EN_SECOND_OR_LOAD_I))
    else $error("mode strap not captured during clear");

  load_write_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    bus.ld_wr |=> wr_ptr == $past(wr_ptr))
    else $error("offset load also wrote the queue");

  drive_follow_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    OUT_DRIVE_EN_N_I ##1 OUT_DRIVE_EN_N_I |-> RD_DATA_OE_N_O)
    else $error("data pins driven while drive enable high");

  drive_on_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !OUT_DRIVE_EN_N_I |=> !RD_DATA_OE_N_O)
    else $error("data pins released while drive enable low");

  write_step_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    fifo_wr |=> wr_ptr == $past(wr_ptr) + 1'b1)
    else $error("accepted write did not advance the write pointer");

  pin_block_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CLEAR_N_I && !load_mode && bus.wr_stb && !WR_EN_SECOND_OR_LOAD_I
    |=> wr_ptr == $past(wr_ptr))
    else $error("write taken with second enable low");

  load_gate_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    load_mode && wr_req && WR_EN_SECOND_OR_LOAD_I && FULL_FLAG_N_O
    |=> wr_ptr == $past(wr_ptr) + 1'b1)
    else $error("load mode write not stored");

  idle_write_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CLEAR_N_I && WR_EN_PRIMARY_N_I |=> wr_ptr == $past(wr_ptr))
    else $error("write pointer moved with primary enable high");

  idle_read_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CLEAR_N_I && RD_EN_PRIMARY_N_I |=> rd_ptr == $past(rd_ptr))
    else $error("read pointer moved with read enable high");

  empty_block_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CLEAR_N_I && !EMPTY_FLAG_N_O |=> rd_ptr == $past(rd_ptr))
    else $error("read accepted while empty");

  clear_ptrs_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !CLEAR_N_I |=> wr_ptr == '0 && rd_ptr == '0)
    else $error("clear left a pointer away from zero");

  clear_drop_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !CLEAR_N_I |-> !fifo_wr && !fifo_rd && !bus.ld_wr && !bus.ld_rd)
    else $error("request taken during clear");

  edge_free_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !CLEAR_N_I |=> wr_clk_q == $past(WR_CLK_I) && rd_clk_q == $past(RD_CLK_I))
    else $error("clock pin history lost during clear");

  strap_hold_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CLEAR_N_I |=> $stable(load_mode))
    else $error("mode strap moved outside clear");

  offset_read_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    bus.ld_rd |=> RD_DATA_O == WIDTH'($past(bus.rd_byte)))
    else $error("offset read did not reach the output register");

  empty_release_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CLEAR_N_I && bus.rd_stb && bus.next_count != '0 |=> EMPTY_FLAG_N_O)
    else $error("empty flag held with words stored");

  empty_set_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CLEAR_N_I && bus.rd_stb && bus.next_count == '0 |=> !EMPTY_FLAG_N_O)
    else $error("empty flag released with nothing stored");

  full_release_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CLEAR_N_I && bus.wr_stb && !bus.next_count[AW] |=> FULL_FLAG_N_O)
    else $error("full flag held with room left");

  full_set_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CLEAR_N_I && bus.wr_stb && bus.next_count[AW] |=> !FULL_FLAG_N_O)
    else $error("full flag not set at full depth");

  count_bound_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (bus.next_count <= (AW+1)'(DEPTH)))
    else $error("stored word count above depth");

endmodule

// >>> far_side.sv
// ------------------------------------------------------------
// writer and reader logic driving one channel's pins
// ------------------------------------------------------------
module far_side
  import fifo_pkg::*;
(
  // clock
  input  wire logic                 clk_i,
  // writer pins
  output logic                      wr_clk_o,
  output logic                      wr_en_n_o,
  output logic                      wr_pin_o,
  output logic      [WIDTH_DEF-1:0] wr_data_o,
  // reader pins
  output logic                      rd_clk_o,
  output logic                      rd_en1_n_o,
  output logic                      rd_en2_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    wr_clk_o   = 1'b0;
    wr_en_n_o  = 1'b1;
    wr_pin_o   = 1'b1;
    wr_data_o  = '0;
    rd_clk_o   = 1'b0;
    rd_en1_n_o = 1'b1;
    rd_en2_n_o = 1'b1;
  end

  // ------------------------------------------------------------
  // one clock pin edge per wr_edge or rd_edge call, none from set_pin; read and write never overlap
  // ------------------------------------------------------------
  task automatic wr_edge(input logic en_n, input logic pin,
                         input logic [WIDTH_DEF-1:0] d);
    @(posedge clk_i);
    #1;
    wr_clk_o  = 1'b0;
    wr_en_n_o = en_n;
    wr_pin_o  = pin;
    wr_data_o = d;
    @(posedge clk_i);
    #1;
    wr_clk_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_clk_o  = 1'b0;
    wr_en_n_o = 1'b1;
    // released bus shows the inverse so a stale word is never mistaken for data
    wr_data_o = ~d;
  endtask

  task automatic rd_edge(input logic e1, input logic e2);
    @(posedge clk_i);
    #1;
    rd_clk_o   = 1'b0;
    rd_en1_n_o = e1;
    rd_en2_n_o = e2;
    @(posedge clk_i);
    #1;
    rd_clk_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_clk_o   = 1'b0;
    rd_en1_n_o = 1'b1;
    rd_en2_n_o = 1'b1;
  endtask

  task automatic set_pin(input logic p);
    @(posedge clk_i);
    #1;
    wr_pin_o = p;
  endtask
endmodule

// >>> tb_top.sv
module tb_top
  import fifo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // signals and model state
  // ------------------------------------------------------------
  logic                 ref_clk = 1'b0;
  logic                 rst     = 1'b1;
  logic                 clear_n = 1'b1;
  logic                 oe_n    = 1'b1;
  logic                 wr_clk, wr_en_n, wr_pin, rd_clk, rd_en1_n, rd_en2_n;
  logic [WIDTH_DEF-1:0] wr_data, rd_data;
  logic                 rd_oe_n, ef_n, ff_n, ae_n, af_n;
  int                   bad_count = 0;
  int                   tests_run = 0;
  int                   seed      = 49100;
  int                   q[$];
  logic                 lm;
  logic [7:0]           off [4];
  int                   ws, rs;
  logic [WIDTH_DEF-1:0] last;
  // model flags in order empty, almost empty, full, almost full
  logic [3:0]           flg;

  always #4 ref_clk = ~ref_clk;

  far_side far (.clk_i(ref_clk), .wr_clk_o(wr_clk), .wr_en_n_o(wr_en_n), .wr_pin_o(wr_pin),
    .wr_data_o(wr_data), .rd_clk_o(rd_clk), .rd_en1_n_o(rd_en1_n), .rd_en2_n_o(rd_en2_n));

  sync_fifo_chan #(.DEPTH(DEPTH_DEF), .WIDTH(WIDTH_DEF)) DUT (
    .REF_CLK_I(ref_clk), .RST_I(rst), .CLEAR_N_I(clear_n), .WR_CLK_I(wr_clk),
    .WR_EN_PRIMARY_N_I(wr_en_n), .WR_EN_SECOND_OR_LOAD_I(wr_pin), .WR_DATA_I(wr_data),
    .RD_CLK_I(rd_clk), .RD_EN_PRIMARY_N_I(rd_en1_n), .RD_EN_SECOND_N_I(rd_en2_n),
    .OUT_DRIVE_EN_N_I(oe_n), .RD_DATA_O(rd_data), .RD_DATA_OE_N_O(rd_oe_n),
    .EMPTY_FLAG_N_O(ef_n), .FULL_FLAG_N_O(ff_n), .ALMOST_EMPTY_N_O(ae_n),
    .ALMOST_FULL_N_O(af_n));

  // ------------------------------------------------------------
  // compares and closing
  // ------------------------------------------------------------
  task automatic chk_data(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t flags %b expected %b", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic int thr(input int i);
    // high bits beyond the pointer width are stored but ignored
    return int'({off[i+1], off[i]}) % DEPTH_DEF;
  endfunction

  function automatic logic [8:0] rnd();
    return 9'($random(seed));
  endfunction

  // ------------------------------------------------------------
  // operations with the reference model
  // ------------------------------------------------------------
  task automatic do_reset(input logic pin);
    @(posedge ref_clk);
    #1;
    rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    far.set_pin(pin);
    clear_n = 1'b0;
    // pin clocks keep running through clear with every enable idle
    far.wr_edge(1'b1, pin, '0);
    far.rd_edge(1'b1, 1'b1);
    clear_n = 1'b1;
    q.delete();
    off = '{OFFSET_RST_LOW, OFFSET_RST_HIGH, OFFSET_RST_LOW, OFFSET_RST_HIGH};
    ws = 0;
    rs = 0;
    last = '0;
    flg = 4'b0011;
    lm = !pin;
    chk_flags({ef_n, ae_n, ff_n, af_n}, flg);
    chk_data(rd_data, last);
  endtask

  task automatic do_wr(input logic en_n, input logic pin, input logic [8:0] d, input bit chk);
    far.wr_edge(en_n, pin, d);
    if (!en_n && lm && !pin) begin
      off[ws] = d[7:0];
      ws = (ws + 1) % 4;
    end else if (!en_n && (lm || pin) && flg[1]) q.push_back(int'(d));
    flg[1] = q.size() != DEPTH_DEF;
    flg[0] = (DEPTH_DEF - q.size()) > thr(2);
    if (chk) chk_flags({ef_n, ae_n, ff_n, af_n}, flg);
  endtask

  task automatic do_rd(input logic e1, input logic e2, input bit chk);
    far.rd_edge(e1, e2);
    if (!e1 && !e2 && lm && !wr_pin) begin
      last = {1'b0, off[rs]};
      rs = (rs + 1) % 4;
    end else if (!e1 && !e2 && flg[3]) last = 9'(q.pop_front());
    flg[3] = q.size() != 0;
    flg[2] = q.size() > thr(0);
    chk_data(rd_data, last);
    if (chk) chk_flags({ef_n, ae_n, ff_n, af_n}, flg);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    $display("[FAIL] %0t run did not finish", $time);
    conclude();
  end

  initial begin
    do_reset(1'b1);
    @(posedge ref_clk);
    #1;
    oe_n = 1'b0;
    @(posedge ref_clk);
    #1;
    chk_data({8'h00, rd_oe_n}, 9'h000);
    oe_n = 1'b1;
    @(posedge ref_clk);
    #1;
    chk_data({8'h00, rd_oe_n}, 9'h001);
    $display("test reset done");
    do_wr(1'b0, 1'b0, rnd(), 1'b1);
    do_rd(1'b0, 1'b0, 1'b1);
    do_wr(1'b1, 1'b1, rnd(), 1'b1);
    for (int i = 0; i <= DEPTH_DEF; i++) do_wr(1'b0, 1'b1, rnd(), 1'b1);
    do_rd(1'b1, 1'b0, 1'b1);
    do_rd(1'b0, 1'b1, 1'b1);
    for (int i = 0; i <= DEPTH_DEF; i++) do_rd(1'b0, 1'b0, 1'b1);
    do_wr(1'b0, 1'b1, rnd(), 1'b1);
    do_wr(1'b0, 1'b1, rnd(), 1'b1);
    do_rd(1'b0, 1'b0, 1'b1);
    do_rd(1'b0, 1'b0, 1'b1);
    $display("test two enable done");
    do_reset(1'b0);
    for (int i = 0; i < 4; i++) do_rd(1'b0, 1'b0, 1'b0);
    do_wr(1'b0, 1'b0, 9'h002, 1'b0);
    do_wr(1'b0, 1'b0, 9'h155, 1'b0);
    do_wr(1'b0, 1'b0, 9'h003, 1'b0);
    for (int i = 0; i < 3; i++) do_wr(1'b0, 1'b1, rnd(), 1'b1);
    do_wr(1'b0, 1'b0, 9'h000, 1'b0);
    do_wr(1'b0, 1'b0, 9'h101, 1'b0);
    do_wr(1'b1, 1'b1, 9'h000, 1'b1);
    do_rd(1'b0, 1'b0, 1'b1);
    do_wr(1'b1, 1'b0, 9'h000, 1'b0);
    for (int i = 0; i < 4; i++) do_rd(1'b0, 1'b0, 1'b0);
    do_wr(1'b1, 1'b1, 9'h000, 1'b0);
    for (int i = 0; i < 4; i++) do_rd(1'b0, 1'b0, 1'b1);
    $display("test load mode done");
    conclude();
  end
endmodule
